// >>> common/eirqf_pkg.sv
package eirqf_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] EIRQF_CH2_CONFIG_ADDR = 12'hfd9;
   localparam logic [11:0] EIRQF_CH3_CONFIG_ADDR = 12'hfda;
   localparam logic [11:0] EIRQF_GATE_ADDR = 12'hf77;
   localparam logic [11:0] EIRQF_STATUS_ADDR = 12'hfe0;
   localparam logic [11:0] EIRQF_MASK_ADDR = 12'hfe1;
   localparam logic [7:0] EIRQF_CONFIG_RESET = 8'h00;
   localparam logic [7:0] EIRQF_MASK_RESET = 8'h00;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int EIRQF_LEVEL_BIT = 4;
   localparam int EIRQF_EDGE_LSB = 2;
   localparam int EIRQF_RATE_LSB = 0;
   localparam int EIRQF_GATE_CH2_BIT = 2;
   localparam int EIRQF_GATE_CH3_BIT = 3;
   // ----------------------------------------
   // Encodings and timing
   // ----------------------------------------
   localparam logic [1:0] EIRQF_EDGE_RISE = 2'h0;
   localparam logic [1:0] EIRQF_EDGE_FALL = 2'h1;
   localparam logic [1:0] EIRQF_EDGE_BOTH = 2'h2;
   localparam logic [3:0] EIRQF_LOW_CLOCK_DIV = 4'h4;
   localparam int EIRQF_FILTER_SAMPLES = 3;
endpackage

// >>> common/eirqf_cfg_if.sv
// Configuration and result bundle for one channel
interface eirqf_cfg_if;
   logic gate;
   logic [1:0] edge_select;
   logic [1:0] filter_rate;
   logic low_speed;
   logic low_tick;
   logic request;
   logic level;
   modport ctrl (output gate, output edge_select, output filter_rate, output low_speed, output low_tick,
      input request, input level);
   modport chan (input gate, input edge_select, input filter_rate, input low_speed, input low_tick,
      output request, output level);
endinterface

// >>> hw/eirqf_rate_div.sv
// ----------------------------------------
// Low clock prescaler: one pulse every fourth low clock tick
// ----------------------------------------
module eirqf_rate_div (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   output logic pulse_o
);
   logic [3:0] cnt_ff;
   // Count ticks, emit a pulse on the fourth
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= 4'h0;
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= 1'b0;
         if (tick_i) begin
            if (cnt_ff == eirqf_pkg::EIRQF_LOW_CLOCK_DIV - 4'h1) begin
               cnt_ff <= 4'h0;
               pulse_o <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff + 4'h1;
            end
         end
      end
   end
endmodule

// >>> hw/eirqf_channel.sv
// ----------------------------------------
// One channel: sampler, noise filter, edge detector
// ----------------------------------------
module eirqf_channel (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   eirqf_cfg_if.chan cfg
);
   logic [3:0] div_ff;
   logic [2:0] shift_ff;
   logic filt_ff;
   logic sample_en;
   logic fast_en;
   logic nxt_filt;
   logic hit;

   // Gear divider enable for codes 00..11: /1, /4, /8, /16
   always_comb begin
      case (cfg.filter_rate)
         2'h0: fast_en = 1'b1;
         2'h1: fast_en = (div_ff[1:0] == 2'h3);
         2'h2: fast_en = (div_ff[2:0] == 3'h7);
         default: fast_en = (div_ff == 4'hf);
      endcase
      sample_en = cfg.low_speed ? cfg.low_tick : fast_en;
   end

   // Free divider, held in reset while gated off
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_ff <= 4'h0;
      end else if (!cfg.gate) begin
         div_ff <= 4'h0;
      end else begin
         div_ff <= div_ff + 4'h1;
      end
   end

   // Filter passes a level only after three equal samples; shorter pulses are noise
   assign nxt_filt = (shift_ff == 3'h7) ? 1'b1 : (shift_ff == 3'h0) ? 1'b0 : filt_ff;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_ff <= 3'h0;
         filt_ff <= 1'b0;
      end else if (!cfg.gate) begin
         shift_ff <= 3'h0;
         filt_ff <= 1'b0;
      end else if (sample_en) begin
         shift_ff <= {shift_ff[1:0], pin_i};
         filt_ff <= nxt_filt;
      end
   end

   // Edge condition on the filtered level
   always_comb begin
      case (cfg.edge_select)
         eirqf_pkg::EIRQF_EDGE_RISE: hit = nxt_filt & ~filt_ff;
         eirqf_pkg::EIRQF_EDGE_FALL: hit = ~nxt_filt & filt_ff;
         eirqf_pkg::EIRQF_EDGE_BOTH: hit = nxt_filt ^ filt_ff;
         default: hit = 1'b0; // Reserved code raises nothing
      endcase
   end

   // Request pulse and level captured with it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg.request <= 1'b0;
         cfg.level <= 1'b0;
      end else begin
         cfg.request <= cfg.gate & sample_en & hit;
         if (!cfg.gate) begin
            cfg.level <= 1'b0;
         end else if (sample_en && hit) begin
            cfg.level <= nxt_filt;
         end
      end
   end
endmodule

// >>> hw/eirqf_top.sv
// ----------------------------------------
// Two-channel external interrupt filter block
// ----------------------------------------
//
// The address-and-strobe port was decided locally.
module eirqf_top (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic [11:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic LOW_SPEED_I,
   input wire logic LOW_TICK_I,
   input wire logic EXT_IRQ_CH2_I,
   input wire logic EXT_IRQ_CH3_I,
   output logic [7:0] RDATA_O,
   output logic REQ_CH2_O,
   output logic REQ_CH3_O,
   output logic IRQ_O
);
   eirqf_cfg_if ch2 ();
   eirqf_cfg_if ch3 ();
   logic [7:0] gate_ff;
   logic [3:0] ch2_cfg_ff;
   logic [3:0] ch3_cfg_ff;
   logic [1:0] status_ff;
   logic [1:0] mask_ff;
   logic low_pulse;
   logic [7:0] nxt_rdata;
   logic status_rd;

   // ----------------------------------------
   // Shared slow sample enable
   // ----------------------------------------
   eirqf_rate_div u_div (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .tick_i(LOW_TICK_I),
      .pulse_o(low_pulse)
   );

   // Configuration fan out to each channel
   assign ch2.gate = gate_ff[eirqf_pkg::EIRQF_GATE_CH2_BIT];
   assign ch2.edge_select = ch2_cfg_ff[eirqf_pkg::EIRQF_EDGE_LSB +: 2];
   assign ch2.filter_rate = ch2_cfg_ff[eirqf_pkg::EIRQF_RATE_LSB +: 2];
   assign ch2.low_speed = LOW_SPEED_I;
   assign ch2.low_tick = low_pulse;
   assign ch3.gate = gate_ff[eirqf_pkg::EIRQF_GATE_CH3_BIT];
   assign ch3.edge_select = ch3_cfg_ff[eirqf_pkg::EIRQF_EDGE_LSB +: 2];
   assign ch3.filter_rate = ch3_cfg_ff[eirqf_pkg::EIRQF_RATE_LSB +: 2];
   assign ch3.low_speed = LOW_SPEED_I;
   assign ch3.low_tick = low_pulse;

   // ----------------------------------------
   // Independent channel instances
   // ----------------------------------------
   eirqf_channel u_ch2 (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .pin_i(EXT_IRQ_CH2_I),
      .cfg(ch2.chan)
   );
   eirqf_channel u_ch3 (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .pin_i(EXT_IRQ_CH3_I),
      .cfg(ch3.chan)
   );

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Gate register
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         gate_ff <= eirqf_pkg::EIRQF_CONFIG_RESET;
      end else if (WR_I && ADDR_I == eirqf_pkg::EIRQF_GATE_ADDR) begin
         gate_ff <= WDATA_I;
      end
   end

   // Channel configs; a closed gate voids them and blocks writes
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ch2_cfg_ff <= eirqf_pkg::EIRQF_CONFIG_RESET[3:0];
         ch3_cfg_ff <= eirqf_pkg::EIRQF_CONFIG_RESET[3:0];
      end else begin
         if (!ch2.gate) begin
            ch2_cfg_ff <= eirqf_pkg::EIRQF_CONFIG_RESET[3:0];
         end else if (WR_I && ADDR_I == eirqf_pkg::EIRQF_CH2_CONFIG_ADDR) begin
            ch2_cfg_ff <= WDATA_I[3:0];
         end
         if (!ch3.gate) begin
            ch3_cfg_ff <= eirqf_pkg::EIRQF_CONFIG_RESET[3:0];
         end else if (WR_I && ADDR_I == eirqf_pkg::EIRQF_CH3_CONFIG_ADDR) begin
            ch3_cfg_ff <= WDATA_I[3:0];
         end
      end
   end

   // Mask register
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mask_ff <= eirqf_pkg::EIRQF_MASK_RESET[1:0];
      end else if (WR_I && ADDR_I == eirqf_pkg::EIRQF_MASK_ADDR) begin
         mask_ff <= WDATA_I[1:0];
      end
   end

   // ----------------------------------------
   // Sticky status, cleared by read; a new request wins over the clear
   // ----------------------------------------
   assign status_rd = RD_I && (ADDR_I == eirqf_pkg::EIRQF_STATUS_ADDR);
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         status_ff <= 2'h0;
      end else begin
         status_ff <= (status_rd ? 2'h0 : status_ff) | {ch3.request, ch2.request};
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      nxt_rdata = 8'h00;
      if (ADDR_I == eirqf_pkg::EIRQF_CH2_CONFIG_ADDR) begin
         nxt_rdata = {3'h0, ch2.level, ch2_cfg_ff};
      end else if (ADDR_I == eirqf_pkg::EIRQF_CH3_CONFIG_ADDR) begin
         nxt_rdata = {3'h0, ch3.level, ch3_cfg_ff};
      end else if (ADDR_I == eirqf_pkg::EIRQF_GATE_ADDR) begin
         nxt_rdata = gate_ff;
      end else if (ADDR_I == eirqf_pkg::EIRQF_STATUS_ADDR) begin
         nxt_rdata = {6'h00, status_ff};
      end else if (ADDR_I == eirqf_pkg::EIRQF_MASK_ADDR) begin
         nxt_rdata = {6'h00, mask_ff};
      end
   end

   // Registered outputs
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RDATA_O <= 8'h00;
         REQ_CH2_O <= 1'b0;
         REQ_CH3_O <= 1'b0;
         IRQ_O <= 1'b0;
      end else begin
         RDATA_O <= RD_I ? nxt_rdata : 8'h00;
         REQ_CH2_O <= ch2.request;
         REQ_CH3_O <= ch3.request;
         IRQ_O <= |(((status_rd ? 2'h0 : status_ff) | {ch3.request, ch2.request}) & mask_ff);
      end
   end
endmodule

// >>> tb/eirqf_assertions.sv
// ---
// Port checks
// ---
module eirqf_assertions (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic [11:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [7:0] RDATA_O,
   input wire logic REQ_CH2_O,
   input wire logic REQ_CH3_O,
   input wire logic IRQ_O
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);
   logic [1:0] mask_ff;
   // Mask shadow, so no hidden state is needed
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mask_ff <= 2'h0;
      end else if (WR_I && ADDR_I == eirqf_pkg::EIRQF_MASK_ADDR) begin
         mask_ff <= WDATA_I[1:0];
      end
   end
   sequence cfg_rd_s;
      RD_I && (ADDR_I == eirqf_pkg::EIRQF_CH2_CONFIG_ADDR || ADDR_I == eirqf_pkg::EIRQF_CH3_CONFIG_ADDR);
   endsequence
   // One cycle of lag is tolerated after the clearing read
   sequence stat_clr_s;
      RD_I && ADDR_I == eirqf_pkg::EIRQF_STATUS_ADDR ##1 (!REQ_CH2_O && !REQ_CH3_O) [*2];
   endsequence
   rd_idle_zero_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
      else $error("read data outside read slot");
   cfg_upper_zero_a: assert property (cfg_rd_s |=> RDATA_O[7:5] == 3'h0)
      else $error("config upper bits not zero");
   req2_pulse_a: assert property (REQ_CH2_O |=> !REQ_CH2_O [*2])
      else $error("ch2 request too long");
   req3_pulse_a: assert property (REQ_CH3_O |=> !REQ_CH3_O [*2])
      else $error("ch3 request too long");
   irq_masked_a: assert property (IRQ_O |-> (mask_ff | $past(mask_ff)) != 2'h0)
      else $error("irq with all masked");
   irq_on_req_a: assert property (REQ_CH2_O && mask_ff[0] && $past(mask_ff[0]) |-> IRQ_O)
      else $error("irq missing on request");
   // A mask write lands one cycle before it shows on the output, so the write before this edge is excluded
   irq_sticky_a: assert property (IRQ_O && !RD_I && !$past(WR_I) |=> IRQ_O)
      else $error("irq dropped unread");
   stat_clear_a: assert property (stat_clr_s |-> !IRQ_O)
      else $error("irq kept after read");
endmodule

bind eirqf_top eirqf_assertions u_chk (.SYS_CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
   .REQ_CH2_O, .REQ_CH3_O, .IRQ_O);

// >>> tb/eirqf_pin_model.sv
// ---
// Off-chip pin: holds a level for a count of cycles
// ---
module eirqf_pin_model (
   input wire logic clk_i,
   output logic pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pin_o = 1'b0;
   // Changes only after an edge, as a synchronous source would
   task automatic hold(input logic lvl, input int cyc);
      @(posedge clk_i);
      pin_o <= lvl;
      repeat (cyc) @(posedge clk_i);
   endtask
endmodule

// >>> tb/eirqf_top_tb_top.sv
// ---
// Register and request tests
// ---
module eirqf_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] a_c2 = eirqf_pkg::EIRQF_CH2_CONFIG_ADDR;
   localparam logic [11:0] a_c3 = eirqf_pkg::EIRQF_CH3_CONFIG_ADDR;
   localparam logic [11:0] a_st = eirqf_pkg::EIRQF_STATUS_ADDR;
   logic clk, pin2, pin3, req2, req3, irq;
   logic rst = 1'b1, wr = 1'b0, rd = 1'b0, slow = 1'b0, tick = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00, rdata, got;
   int failures = 0, checked = 0, n2 = 0, n3 = 0, tcnt = 0, base, lat, d;
   eirqf_top u_eirqf_top (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .LOW_SPEED_I(slow), .LOW_TICK_I(tick), .EXT_IRQ_CH2_I(pin2), .EXT_IRQ_CH3_I(pin3),
      .RDATA_O(rdata), .REQ_CH2_O(req2), .REQ_CH3_O(req3), .IRQ_O(irq));
   eirqf_pin_model u_pin2 (.clk_i(clk), .pin_o(pin2));
   eirqf_pin_model u_pin3 (.clk_i(clk), .pin_o(pin3));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Low clock tick every fifth cycle; requests of both channels are tallied
   always @(posedge clk) begin
      tcnt <= (tcnt + 1) % 5;
      tick <= (tcnt == 0);
      n2 <= n2 + int'(req2);
      n3 <= n3 + int'(req3);
   end
   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd_chk(input string w, input logic [11:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 got = rdata;
      if (w != "") chk(w, e, got);
   endtask
   // Sample phase is unknown: first sample lands 1 to d cycles late, the level flips
   // on the sample after three equal ones, and the request output adds one register
   task automatic edge_lat(input int lo, input int hi);
      lat = 0;
      u_pin2.hold(1'b1, 0);
      while (req2 !== 1'b1 && lat < 100) begin
         @(posedge clk);
         #1 lat++;
      end
      chk("latency", 8'h01, 8'(lat >= lo && lat <= hi));
      u_pin2.hold(1'b0, 100);
   endtask
   task automatic test_done();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd_chk("ch2 reset", a_c2, 8'h00);
      rd_chk("ch3 reset", a_c3, 8'h00);
      rd_chk("unmapped", 12'h000, 8'h00);
      wr_reg(a_c2, 8'h0b);
      rd_chk("gated write", a_c2, 8'h00);
      wr_reg(eirqf_pkg::EIRQF_GATE_ADDR, 8'h0c);
      wr_reg(a_c2, 8'hff);
      rd_chk("upper bits", a_c2, 8'h0f);
      $display("registers done");
      for (int es = 0; es < 4; es++) begin
         wr_reg(a_c2, 8'(es << 2));
         base = n2;
         u_pin2.hold(1'b1, 10);
         u_pin2.hold(1'b0, 10);
         chk("edge count", 8'(es == 2 ? 2 : es == 3 ? 0 : 1), 8'(n2 - base));
         rd_chk("level", a_c2, 8'({es == 0, 2'(es), 2'h0}));
      end
      for (int r = 0; r < 4; r++) begin
         d = (r == 0) ? 1 : 2 << r;
         wr_reg(a_c2, 8'(r));
         edge_lat(eirqf_pkg::EIRQF_FILTER_SAMPLES * d + 2, (eirqf_pkg::EIRQF_FILTER_SAMPLES + 1) * d + 1);
      end
      slow <= 1'b1;
      repeat (60) @(posedge clk);
      rd_chk("", a_st, 8'h00);
      wr_reg(a_c2, 8'h00);
      d = 5 * int'(eirqf_pkg::EIRQF_LOW_CLOCK_DIV);
      edge_lat(eirqf_pkg::EIRQF_FILTER_SAMPLES * d + 2, (eirqf_pkg::EIRQF_FILTER_SAMPLES + 1) * d + 1);
      slow <= 1'b0;
      repeat (5) @(posedge clk);
      rd_chk("", a_st, 8'h00);
      $display("filter done");
      wr_reg(eirqf_pkg::EIRQF_MASK_ADDR, 8'h01);
      base = n2;
      u_pin3.hold(1'b1, 10);
      chk("ch2 quiet", 8'h00, 8'(n2 - base));
      chk("ch3 masked", 8'h00, 8'(irq));
      chk("ch3 request", 8'h01, 8'(n3));
      u_pin2.hold(1'b1, 10);
      chk("irq set", 8'h01, 8'(irq));
      rd_chk("status", a_st, 8'h03);
      repeat (2) @(posedge clk);
      chk("irq clear", 8'h00, 8'(irq));
      rd_chk("ch2 level", a_c2, 8'h10);
      wr_reg(a_c3, 8'h0a);
      wr_reg(eirqf_pkg::EIRQF_GATE_ADDR, 8'h08);
      rd_chk("voided", a_c2, 8'h00);
      rd_chk("ch3 kept", a_c3, 8'h1a);
      $display("interrupts done");
      test_done();
   end
   // Whole run needs about a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      test_done();
   end
endmodule
